// File: rtl/power_sequencer.v
// Behaviour
// - sleep request bit enters power-down
// - power-down stops pll and core clock
// - oscillator halts in sleep when bit set
// - only interval timer stays alive asleep; here its clock stops too when the oscillator halts
// - port pins hold levels while asleep
// - dac tri-stated, ale psen driven low
// - reset pin ends sleep, restores defaults
// - power cycle restarts after 128 ms
// - interval timer interrupt wakes, resumes after; here only when the oscillator is not halted in sleep
// - enabled spi interrupt wakes when allowed
// - enabled ext0 interrupt wakes when allowed
// - pll lock takes 1 ms after wake
// - halted crystal adds 150 ms start-up
// - pll lock status readable at bit 6
// - 3 V part: 2.63 V, then 128 ms
// - 5 V part: 4.5 V, then 128 ms
// - reset held during supply collapse
// - core clock divider lowers core rate
//
// Local design decisions: the register offsets and the AXI4-Lite slave port.
`include "pwr_seq_defines.vh"

module power_sequencer #(
   parameter VARIANT_5V = 0,
   parameter [`TIMER_W-1:0] POR_CYCLES = `POR_CYCLES,
   parameter [`TIMER_W-1:0] OSC_START_CYCLES = `OSC_START_CYCLES,
   parameter [`TIMER_W-1:0] PLL_LOCK_CYCLES = `PLL_LOCK_CYCLES
) (
   input wire i_sys_clk,
   input wire i_nrst,
   // axi4-lite slave
   input wire i_awvalid,
   output reg o_awready,
   input wire [7:0] i_awaddr,
   input wire i_wvalid,
   output reg o_wready,
   input wire [31:0] i_wdata,
   input wire [3:0] i_wstrb,
   output reg o_bvalid,
   input wire i_bready,
   output reg [1:0] o_bresp,
   input wire i_arvalid,
   output reg o_arready,
   input wire [7:0] i_araddr,
   output reg o_rvalid,
   input wire i_rready,
   output reg [31:0] o_rdata,
   output reg [1:0] o_rresp,
   // pins and comparators, asynchronous
   input wire i_reset_pin,
   input wire i_ext0_pin,
   input wire i_supply_above_263,
   input wire i_supply_above_450,
   // same-clock peripheral signals
   input wire i_tic_enabled,
   input wire i_tic_irq,
   input wire i_spi_irq,
   input wire i_spi_irq_en,
   input wire i_ext0_irq_en,
   // outputs to the chip
   output reg o_core_rst,
   output reg o_core_clk_en,
   output reg o_pll_en,
   output reg o_osc_en,
   output reg o_tic_clk_en,
   output reg o_periph_en,
   output reg o_port_hold,
   output reg o_dac_hiz,
   output reg o_ale_force_low,
   output reg o_psen_force_low,
   output reg o_pll_locked,
   output reg o_wake_irq,
   output reg [2:0] o_wake_src
);

   // ****************************************
   // states
   // ****************************************
   localparam [2:0] ST_RESET = 3'h0;
   localparam [2:0] ST_RUN = 3'h1;
   localparam [2:0] ST_SLEEP = 3'h2;
   localparam [2:0] ST_OSC_START = 3'h3;
   localparam [2:0] ST_PLL_LOCK = 3'h4;

   // ****************************************
   // input synchronisers
   // ****************************************
   localparam NSYNC = 4;
   wire [NSYNC-1:0] async_in;
   reg [NSYNC-1:0] sync1;
   reg [NSYNC-1:0] sync2;
   assign async_in = {i_supply_above_450, i_supply_above_263, i_ext0_pin, i_reset_pin};

   genvar g;
   generate
      for (g = 0; g < NSYNC; g = g + 1) begin : g_sync
         always @(posedge i_sys_clk or negedge i_nrst) begin
            if (!i_nrst) begin
               sync1[g] <= 1'b0;
               sync2[g] <= 1'b0;
            end else begin
               sync1[g] <= async_in[g];
               sync2[g] <= sync1[g];
            end
         end
      end
   endgenerate

   wire reset_pin = sync2[0];
   wire ext0_irq = sync2[1];
   wire supply_ok = (VARIANT_5V != 0) ? sync2[3] : sync2[2];

   // ****************************************
   // power-on reset
   // ****************************************
   reg por_hold;
   reg por_armed;
   wire por_done;
   wire por_start = supply_ok & ~por_armed;

   delay_timer #(.W(`TIMER_W)) u_por_timer (
      .i_sys_clk(i_sys_clk),
      .i_nrst(i_nrst),
      .i_clear(~supply_ok),
      .i_start(por_start),
      .i_count(POR_CYCLES),
      .o_busy(),
      .o_done(por_done)
   );

   always @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         por_hold <= 1'b1;
         por_armed <= 1'b0;
      end else begin
         if (!supply_ok) begin
            por_hold <= 1'b1;
            por_armed <= 1'b0;
         end else begin
            if (por_start) begin
               por_armed <= 1'b1;
            end
            if (por_done) begin
               por_hold <= 1'b0;
            end
         end
      end
   end

   wire soft_rst = por_hold | reset_pin;

   // ****************************************
   // registers and state
   // ****************************************
   reg sleep_request_bit;
   reg spi_wake_enable;
   reg ext0_wake_enable;
   reg osc_halt_in_sleep;
   reg [2:0] core_clk_divider;
   reg pll_lock;
   reg [2:0] state;
   reg [2:0] wake_src;
   reg wake_pend;
   reg pll_start;
   reg [`TIMER_W-1:0] pll_count;
   wire pll_done;

   delay_timer #(.W(`TIMER_W)) u_pll_timer (
      .i_sys_clk(i_sys_clk),
      .i_nrst(i_nrst),
      .i_clear(soft_rst),
      .i_start(pll_start),
      .i_count(pll_count),
      .o_busy(),
      .o_done(pll_done)
   );

   // timer wakes only with oscillator alive
   wire wake_tic = ~osc_halt_in_sleep & i_tic_enabled & i_tic_irq;
   wire wake_spi = spi_wake_enable & i_spi_irq_en & i_spi_irq;
   wire wake_ext0 = ext0_wake_enable & i_ext0_irq_en & ext0_irq;
   wire wake_any = wake_tic | wake_spi | wake_ext0;

   // ****************************************
   // axi4-lite write path
   // ****************************************
   reg aw_held;
   reg w_held;
   reg [7:0] aw_addr;
   reg [31:0] w_data;
   reg [3:0] w_strb;
   wire aw_take = i_awvalid & o_awready;
   wire w_take = i_wvalid & o_wready;
   wire aw_have = aw_held | aw_take;
   wire w_have = w_held | w_take;
   wire [7:0] wr_addr = aw_held ? aw_addr : i_awaddr;
   wire [31:0] wr_data = w_held ? w_data : i_wdata;
   wire [3:0] wr_strb = w_held ? w_strb : i_wstrb;
   wire wr_fire = aw_have & w_have & ~o_bvalid;
   wire wr_lane0 = wr_fire & wr_strb[0];
   wire wr_pctl = wr_lane0 & (wr_addr == `ADDR_POWER_CTL);
   wire wr_pll = wr_lane0 & (wr_addr == `ADDR_PLL_CTL);
   wire wr_known = (wr_addr == `ADDR_POWER_CTL) | (wr_addr == `ADDR_PLL_CTL) | (wr_addr == `ADDR_STATUS);

   always @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_awready <= 1'b0;
         o_wready <= 1'b0;
         o_bvalid <= 1'b0;
         o_bresp <= `RESP_OKAY;
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
      end else begin
         if (wr_fire) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            o_bvalid <= 1'b1;
            o_bresp <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
         end else begin
            if (aw_take) begin
               aw_held <= 1'b1;
               aw_addr <= i_awaddr;
            end
            if (w_take) begin
               w_held <= 1'b1;
               w_data <= i_wdata;
               w_strb <= i_wstrb;
            end
            if (o_bvalid & i_bready) begin
               o_bvalid <= 1'b0;
            end
         end
         o_awready <= ~aw_have & ~o_bvalid & ~o_awready;
         o_wready <= ~w_have & ~o_bvalid & ~o_wready;
      end
   end

   // ****************************************
   // axi4-lite read path
   // ****************************************
   always @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_arready <= 1'b0;
         o_rvalid <= 1'b0;
         o_rdata <= 32'h00000000;
         o_rresp <= `RESP_OKAY;
      end else begin
         o_arready <= ~o_rvalid & ~o_arready & i_arvalid;
         if (i_arvalid & o_arready) begin
            o_rvalid <= 1'b1;
            o_rresp <= `RESP_OKAY;
            o_rdata <= 32'h00000000;
            case (i_araddr)
               `ADDR_POWER_CTL: begin
                  o_rdata[`PCTL_SLEEP_BIT] <= sleep_request_bit;
                  o_rdata[`PCTL_SPI_WAKE_BIT] <= spi_wake_enable;
                  o_rdata[`PCTL_EXT0_WAKE_BIT] <= ext0_wake_enable;
               end
               `ADDR_PLL_CTL: begin
                  o_rdata[`PLL_CD_MSB:`PLL_CD_LSB] <= core_clk_divider;
                  o_rdata[`PLL_OSC_HALT_BIT] <= osc_halt_in_sleep;
                  o_rdata[`PLL_LOCK_BIT] <= pll_lock;
               end
               `ADDR_STATUS: begin
                  o_rdata[`STAT_STATE_LSB+2:`STAT_STATE_LSB] <= state;
                  o_rdata[`STAT_WAKE_LSB+2:`STAT_WAKE_LSB] <= wake_src;
                  o_rdata[`STAT_POR_BIT] <= por_hold;
               end
               default: begin
                  o_rresp <= `RESP_SLVERR;
               end
            endcase
         end else if (o_rvalid & i_rready) begin
            o_rvalid <= 1'b0;
         end
      end
   end

   // ****************************************
   // sleep / wake sequencer
   // ****************************************
   always @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         sleep_request_bit <= 1'b0;
         spi_wake_enable <= 1'b0;
         ext0_wake_enable <= 1'b0;
         osc_halt_in_sleep <= 1'b0;
         core_clk_divider <= `PLL_CD_RESET;
         pll_lock <= 1'b0;
         state <= ST_RESET;
         wake_src <= 3'h0;
         wake_pend <= 1'b0;
         pll_start <= 1'b0;
         pll_count <= {`TIMER_W{1'b0}};
         o_wake_irq <= 1'b0;
         o_wake_src <= 3'h0;
      end else begin
         pll_start <= 1'b0;
         o_wake_irq <= 1'b0;
         wake_pend <= 1'b0;
         if (soft_rst) begin
            sleep_request_bit <= 1'b0;
            spi_wake_enable <= 1'b0;
            ext0_wake_enable <= 1'b0;
            osc_halt_in_sleep <= 1'b0;
            core_clk_divider <= `PLL_CD_RESET;
            pll_lock <= 1'b0;
            state <= ST_RESET;
            wake_src <= 3'h0;
            o_wake_src <= 3'h0;
         end else begin
            if (wr_pctl) begin
               sleep_request_bit <= wr_data[`PCTL_SLEEP_BIT];
               spi_wake_enable <= wr_data[`PCTL_SPI_WAKE_BIT];
               ext0_wake_enable <= wr_data[`PCTL_EXT0_WAKE_BIT];
            end
            if (wr_pll) begin
               core_clk_divider <= wr_data[`PLL_CD_MSB:`PLL_CD_LSB];
               osc_halt_in_sleep <= wr_data[`PLL_OSC_HALT_BIT];
            end
            case (state)
               ST_RESET: begin
                  pll_start <= 1'b1;
                  pll_count <= PLL_LOCK_CYCLES;
                  state <= ST_PLL_LOCK;
               end
               ST_RUN: begin
                  if (sleep_request_bit) begin
                     state <= ST_SLEEP;
                     pll_lock <= 1'b0;
                  end
               end
               ST_SLEEP: begin
                  if (wake_any) begin
                     sleep_request_bit <= 1'b0;
                     wake_src <= {wake_ext0, wake_spi, wake_tic};
                     wake_pend <= 1'b1;
                     pll_start <= 1'b1;
                     if (osc_halt_in_sleep) begin
                        pll_count <= OSC_START_CYCLES;
                        state <= ST_OSC_START;
                     end else begin
                        pll_count <= PLL_LOCK_CYCLES;
                        state <= ST_PLL_LOCK;
                     end
                  end
               end
               ST_OSC_START: begin
                  if (pll_done) begin
                     pll_start <= 1'b1;
                     pll_count <= PLL_LOCK_CYCLES;
                     state <= ST_PLL_LOCK;
                  end
               end
               ST_PLL_LOCK: begin
                  if (pll_done) begin
                     pll_lock <= 1'b1;
                     state <= ST_RUN;
                  end
               end
               default: begin
                  state <= ST_RESET;
               end
            endcase
            // interrupt one cycle later, core clock already back (pll still off while the oscillator starts)
            o_wake_irq <= wake_pend;
            if (wake_pend) begin
               o_wake_src <= wake_src;
            end
         end
      end
   end

   // ****************************************
   // core clock enable divider
   // ****************************************
   // core runs unlocked during osc start and lock, as the part does
   reg [6:0] div_cnt;
   wire asleep = (state == ST_SLEEP);
   wire core_run = ~soft_rst & (state != ST_RESET) & ~asleep;
   wire [6:0] div_mask = (7'h7F >> (3'h7 - core_clk_divider));

   always @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         div_cnt <= 7'h00;
         o_core_clk_en <= 1'b0;
      end else begin
         div_cnt <= div_cnt + 7'h01;
         o_core_clk_en <= core_run & ((div_cnt & div_mask) == 7'h00);
      end
   end

   // ****************************************
   // power-down controls
   // ****************************************
   always @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_core_rst <= 1'b1;
         o_pll_en <= 1'b0;
         o_osc_en <= 1'b1;
         o_tic_clk_en <= 1'b1;
         o_periph_en <= 1'b0;
         o_port_hold <= 1'b0;
         o_dac_hiz <= 1'b0;
         o_ale_force_low <= 1'b0;
         o_psen_force_low <= 1'b0;
         o_pll_locked <= 1'b0;
      end else begin
         o_core_rst <= soft_rst;
         o_pll_en <= ~asleep & ~(state == ST_OSC_START);
         // halted asleep, restarts at wake so start-up can count
         o_osc_en <= ~(asleep & osc_halt_in_sleep) | soft_rst;
         o_tic_clk_en <= ~(asleep & osc_halt_in_sleep) | soft_rst;
         o_periph_en <= ~asleep & ~soft_rst;
         o_port_hold <= asleep;
         // dac off, ale and psen low
         o_dac_hiz <= asleep;
         o_ale_force_low <= asleep;
         o_psen_force_low <= asleep;
         o_pll_locked <= pll_lock;
      end
   end

endmodule

// File: rtl/pwr_seq_defines.vh
`ifndef PWR_SEQ_DEFINES_VH
`define PWR_SEQ_DEFINES_VH

// ****************************************
// register byte addresses
// ****************************************
`define ADDR_POWER_CTL 8'h00
`define ADDR_PLL_CTL 8'h04
`define ADDR_STATUS 8'h08

// ****************************************
// power_ctl_reg fields
// ****************************************
`define PCTL_SLEEP_BIT 1
`define PCTL_SPI_WAKE_BIT 3
`define PCTL_EXT0_WAKE_BIT 5
`define PCTL_RESET 8'h00

// ****************************************
// pll_ctl_reg fields
// ****************************************
`define PLL_CD_LSB 0
`define PLL_CD_MSB 2
`define PLL_OSC_HALT_BIT 3
`define PLL_LOCK_BIT 6
`define PLL_CD_RESET 3'h0

// ****************************************
// status register fields
// ****************************************
`define STAT_STATE_LSB 0
`define STAT_WAKE_LSB 4
`define STAT_POR_BIT 8

// ****************************************
// axi responses
// ****************************************
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ****************************************
// timing
// ****************************************
`define CLK_MHZ 250
`define POR_DELAY_MS 128
`define OSC_START_MS 150
`define PLL_LOCK_MS 1
`define CYCLES_PER_MS (`CLK_MHZ * 1000)
`define POR_CYCLES (`POR_DELAY_MS * `CYCLES_PER_MS)
`define OSC_START_CYCLES (`OSC_START_MS * `CYCLES_PER_MS)
`define PLL_LOCK_CYCLES (`PLL_LOCK_MS * `CYCLES_PER_MS)
`define TIMER_W 26

`endif

// File: rtl/delay_timer.v
module delay_timer #(
   parameter W = 26
) (
   input wire i_sys_clk,
   input wire i_nrst,
   input wire i_clear,
   input wire i_start,
   input wire [W-1:0] i_count,
   output reg o_busy,
   output reg o_done
);

   reg [W-1:0] cnt;

   always @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cnt <= {W{1'b0}};
         o_busy <= 1'b0;
         o_done <= 1'b0;
      end else begin
         o_done <= 1'b0;
         if (i_clear) begin
            cnt <= {W{1'b0}};
            o_busy <= 1'b0;
         end else if (i_start) begin
            cnt <= i_count;
            o_busy <= 1'b1;
         end else if (o_busy) begin
            if (cnt <= {{(W-1){1'b0}}, 1'b1}) begin
               o_busy <= 1'b0;
               o_done <= 1'b1;
            end else begin
               cnt <= cnt - {{(W-1){1'b0}}, 1'b1};
            end
         end
      end
   end

endmodule

// File: sim/power_sequencer_assertions.sv
module pwr_seq_chk #(
   parameter POR_CYC = 20,
   parameter LOCK_CYC = 10
) (
   input wire i_sys_clk,
   input wire i_nrst,
   input wire i_reset_pin,
   input wire i_supply_above_263,
   input wire i_tic_enabled,
   input wire i_tic_irq,
   input wire i_spi_irq,
   input wire i_spi_irq_en,
   input wire i_ext0_irq_en,
   input wire o_core_rst,
   input wire o_core_clk_en,
   input wire o_pll_en,
   input wire o_periph_en,
   input wire o_port_hold,
   input wire o_dac_hiz,
   input wire o_ale_force_low,
   input wire o_psen_force_low,
   input wire o_pll_locked,
   input wire o_wake_irq,
   input wire [2:0] o_wake_src
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_nrst);
   // ****
   // helper counters, saturating so long runs stay quiet
   // ****
   reg [7:0] up_cnt;
   reg [7:0] wk_cnt;
   always @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         up_cnt <= 8'h00;
         wk_cnt <= 8'h00;
      end else begin
         up_cnt <= !i_supply_above_263 ? 8'h00 : (up_cnt == 8'hFF ? up_cnt : up_cnt + 8'h01);
         wk_cnt <= o_wake_irq ? 8'h00 : (wk_cnt == 8'hFF ? wk_cnt : wk_cnt + 8'h01);
      end
   end
   a_sleep_clk_off: assert property (o_port_hold |-> !o_core_clk_en && !o_pll_en)
      else $error("core clock or pll running asleep");
   a_periph_off: assert property (o_port_hold |-> !o_periph_en)
      else $error("peripherals running asleep");
   a_sleep_pins: assert property (o_port_hold == o_dac_hiz && o_dac_hiz == o_ale_force_low
      && o_ale_force_low == o_psen_force_low)
      else $error("pin controls disagree");
   a_wake_pulse: assert property (o_wake_irq |-> !o_port_hold ##1 !o_wake_irq)
      else $error("wake pulse too long or still asleep");
   a_tic_cause: assert property (o_wake_irq && o_wake_src[0] |-> $past(i_tic_enabled && i_tic_irq, 2))
      else $error("timer wake without cause");
   a_spi_cause: assert property (o_wake_irq && o_wake_src[1] |-> $past(i_spi_irq && i_spi_irq_en, 2))
      else $error("spi wake without cause");
   a_ext0_cause: assert property (o_wake_irq && o_wake_src[2] |-> $past(i_ext0_irq_en, 2))
      else $error("ext0 wake while disabled");
   a_pin_reset: assert property (i_reset_pin |-> ##[1:4] o_core_rst)
      else $error("reset pin ignored");
   a_supply_reset: assert property (!i_supply_above_263 |-> ##[1:4] o_core_rst)
      else $error("low supply ignored");
   a_por_delay: assert property ($fell(o_core_rst) |-> up_cnt >= POR_CYC)
      else $error("reset released early");
   a_lock_delay: assert property ($rose(o_pll_locked) |-> wk_cnt >= LOCK_CYC)
      else $error("lock too soon after wake");
endmodule

// File: sim/core_model.sv
module core_model (
   input wire i_sys_clk,
   input wire i_core_rst,
   input wire i_core_clk_en,
   input wire i_wake_irq,
   input wire [2:0] i_wake_src,
   input wire i_pll_locked,
   input wire [1:0] i_en_cfg,
   output reg o_spi_irq_en,
   output reg o_ext0_irq_en,
   output reg [2:0] o_last_src,
   output reg [15:0] o_n_instr,
   output wire o_timing_ok
);
   timeunit 1ns;
   timeprecision 1ps;
   assign o_timing_ok = i_pll_locked && !i_core_rst;
   always @(posedge i_sys_clk) begin
      if (i_core_rst) begin
         o_spi_irq_en <= 1'b0;
         o_ext0_irq_en <= 1'b0;
         o_last_src <= 3'h0;
         o_n_instr <= 16'h0000;
      end else begin
         {o_ext0_irq_en, o_spi_irq_en} <= i_en_cfg;
         if (i_wake_irq && i_core_clk_en) o_last_src <= i_wake_src;
         if (i_core_clk_en) o_n_instr <= o_n_instr + 16'h0001;
      end
   end
endmodule

// File: sim/test_power_sequencer.sv
`include "pwr_seq_defines.vh"
module test_power_sequencer;
   timeunit 1ns;
   timeprecision 1ps;
   localparam POR = 20, OSC = 30, LCK = 10;
   logic i_sys_clk = 0, i_nrst = 0, i_awvalid = 0, i_wvalid = 0, i_bready = 0, i_arvalid = 0, i_rready = 0;
   logic i_reset_pin = 0, i_ext0_pin = 0, i_supply_above_263 = 1, i_supply_above_450 = 0;
   logic i_tic_enabled = 0, i_tic_irq = 0, i_spi_irq = 0, i_spi_irq_en, i_ext0_irq_en, timing_ok;
   logic [7:0] i_awaddr = 0, i_araddr = 0;
   logic [31:0] i_wdata = 0, o_rdata, seed = 32'h84e27100;
   logic [3:0] i_wstrb = 0;
   logic [1:0] en_cfg = 0, o_bresp, o_rresp;
   logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_core_rst, o_core_clk_en, o_pll_en, o_osc_en;
   logic o_tic_clk_en, o_periph_en, o_port_hold, o_dac_hiz, o_ale_force_low, o_psen_force_low, o_pll_locked;
   logic o_wake_irq;
   logic [2:0] o_wake_src, last_src;
   logic [15:0] n_instr;
   int bad_count = 0, n_tests = 0;
   power_sequencer #(.VARIANT_5V(0), .POR_CYCLES(26'd20), .OSC_START_CYCLES(26'd30), .PLL_LOCK_CYCLES(26'd10))
   i_power_sequencer (.i_sys_clk, .i_nrst, .i_awvalid, .o_awready, .i_awaddr, .i_wvalid, .o_wready, .i_wdata,
      .i_wstrb, .o_bvalid, .i_bready, .o_bresp, .i_arvalid, .o_arready, .i_araddr, .o_rvalid, .i_rready, .o_rdata,
      .o_rresp, .i_reset_pin, .i_ext0_pin, .i_supply_above_263, .i_supply_above_450, .i_tic_enabled, .i_tic_irq,
      .i_spi_irq, .i_spi_irq_en, .i_ext0_irq_en, .o_core_rst, .o_core_clk_en, .o_pll_en, .o_osc_en, .o_tic_clk_en,
      .o_periph_en, .o_port_hold, .o_dac_hiz, .o_ale_force_low, .o_psen_force_low, .o_pll_locked, .o_wake_irq,
      .o_wake_src);
   core_model i_core_model (.i_sys_clk, .i_core_rst(o_core_rst), .i_core_clk_en(o_core_clk_en),
      .i_wake_irq(o_wake_irq), .i_wake_src(o_wake_src), .i_pll_locked(o_pll_locked), .i_en_cfg(en_cfg),
      .o_spi_irq_en(i_spi_irq_en), .o_ext0_irq_en(i_ext0_irq_en), .o_last_src(last_src), .o_n_instr(n_instr),
      .o_timing_ok(timing_ok));
   always #2 i_sys_clk = ~i_sys_clk;
   // ****
   // helpers
   // ****
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic sig(int s);
      case (s)
         0: return o_core_rst;
         1: return o_pll_locked;
         2: return o_wake_irq;
         default: return o_port_hold;
      endcase
   endfunction
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %s exp %0h got %0h", nm, exp, got);
      end
   endtask
   task chk_ge(input string nm, input int lo, input int got);
      n_tests++;
      if (got < lo) begin
         bad_count++;
         $display("[ERR] %s exp >=%0d got %0d", nm, lo, got);
      end
   endtask
   // bounded wait, sampled at falling edges where outputs are settled
   task wt(input int s, input logic v, output int n);
      n = 0;
      do begin
         @(negedge i_sys_clk);
         n++;
      end while (sig(s) !== v && n < 2000);
      if (n >= 2000) chk("wait", 0, 1);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic ta, tw, b;
      int n;
      @(posedge i_sys_clk);
      i_awvalid <= 1;
      i_awaddr <= a;
      i_wvalid <= 1;
      i_wdata <= d;
      i_wstrb <= 4'hF;
      i_bready <= 1;
      ta = 0;
      tw = 0;
      b = 0;
      n = 0;
      while (!b && n < 50) begin
         @(negedge i_sys_clk);
         b = ta && tw && o_bvalid;
         r = o_bresp;
         if (!ta && o_awready) ta = 1;
         if (!tw && o_wready) tw = 1;
         @(posedge i_sys_clk);
         n++;
         if (ta) i_awvalid <= 0;
         if (tw) i_wvalid <= 0;
      end
      i_bready <= 0;
      if (!b) chk("write wait", 0, 1);
   endtask
   task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ta, b;
      int n;
      @(posedge i_sys_clk);
      i_arvalid <= 1;
      i_araddr <= a;
      i_rready <= 1;
      ta = 0;
      b = 0;
      n = 0;
      while (!b && n < 50) begin
         @(negedge i_sys_clk);
         b = ta && o_rvalid;
         d = o_rdata;
         r = o_rresp;
         if (!ta && o_arready) ta = 1;
         @(posedge i_sys_clk);
         n++;
         if (ta) i_arvalid <= 0;
      end
      i_rready <= 0;
      if (!b) chk("read wait", 0, 1);
   endtask
   task results();
      $display("mismatches %0d, checks %0d", bad_count, n_tests);
      if (bad_count == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // ****
   // scenarios
   // ****
   initial begin
      logic [31:0] d;
      logic [1:0] r;
      logic h;
      int n, k, s, c;
      repeat (10) @(negedge i_sys_clk);
      chk("rst core", 1, o_core_rst); chk("rst pll", 0, o_pll_en); chk("rst hold", 0, o_port_hold);
      @(posedge i_sys_clk);
      i_nrst <= 1;
      wt(0, 0, n); chk_ge("por delay", POR, n);
      wt(1, 1, n); rd(`ADDR_PLL_CTL, d, r); chk("lock bit", 1, d[`PLL_LOCK_BIT]); chk("poll", 1, timing_ok);
      rd(8'h0C, d, r); chk("bad rd resp", `RESP_SLVERR, r); chk("bad rd data", 0, d);
      wr(8'h10, 32'h0000_0002, r); chk("bad wr resp", `RESP_SLVERR, r);
      rd(`ADDR_POWER_CTL, d, r); chk("pctl dflt", `PCTL_RESET, d);
      for (c = 0; c < 8; c++) begin
         // lock bit written as zero, stays read-only
         wr(`ADDR_PLL_CTL, c, r); rd(`ADDR_PLL_CTL, d, r); chk("pll rd", 32'h40 | c, d[6:0]);
         k = 0;
         repeat (128) begin
            @(negedge i_sys_clk);
            k += o_core_clk_en;
         end
         chk("clk_en count", 128 >> c, k);
      end
      for (s = 0; s < 3; s++) begin
         h = (s == 2);
         wr(`ADDR_PLL_CTL, {28'h0, h, 3'h0}, r);
         @(posedge i_sys_clk);
         i_tic_enabled <= 0;
         en_cfg <= 2'b00;
         wr(`ADDR_POWER_CTL, 32'h0000_002A, r); wt(3, 1, n); k = n_instr;
         chk("clk_en", 0, o_core_clk_en); chk("pll_en", 0, o_pll_en);
         chk("osc_en", !h, o_osc_en); chk("tic clk", !h, o_tic_clk_en); chk("periph", 0, o_periph_en);
         chk("dac", 1, o_dac_hiz); chk("ale", 1, o_ale_force_low); chk("psen", 1, o_psen_force_low);
         @(posedge i_sys_clk);
         i_tic_irq <= (s == 0);
         i_spi_irq <= (s == 1);
         i_ext0_pin <= (s == 2);
         repeat (8 + rnd() % 8) @(negedge i_sys_clk);
         chk("no wake", 1, o_port_hold); chk("core stopped", k, n_instr);
         @(posedge i_sys_clk);
         i_tic_enabled <= (s == 0);
         en_cfg <= 2'b11;
         wt(2, 1, n); chk("wake src", 32'h1 << s, o_wake_src);
         chk("lock off", 0, o_pll_locked); chk("osc start", 1, o_osc_en);
         chk("clk back", 1, o_core_clk_en);
         @(posedge i_sys_clk);
         i_tic_irq <= 0;
         i_spi_irq <= 0;
         i_ext0_pin <= 0;
         wt(1, 1, n); chk_ge("lock time", h ? OSC + LCK : LCK, n);
         chk("isr src", 32'h1 << s, last_src); rd(`ADDR_POWER_CTL, d, r); chk("sleep clr", 0, d[1]);
      end
      wr(`ADDR_PLL_CTL, 32'h1 + rnd() % 7, r);
      wr(`ADDR_POWER_CTL, 32'h0000_002A, r); wt(3, 1, n);
      @(posedge i_sys_clk);
      i_reset_pin <= 1;
      repeat (6) @(negedge i_sys_clk);
      chk("pin rst", 1, o_core_rst); chk("pin wake", 0, o_port_hold);
      @(posedge i_sys_clk);
      i_reset_pin <= 0;
      wt(0, 0, n); rd(`ADDR_POWER_CTL, d, r); chk("pctl back", `PCTL_RESET, d);
      rd(`ADDR_PLL_CTL, d, r); chk("cd back", `PLL_CD_RESET, d[3:0]);
      @(posedge i_sys_clk);
      i_supply_above_263 <= 0;
      repeat (6) @(negedge i_sys_clk);
      chk("supply rst", 1, o_core_rst);
      @(posedge i_sys_clk);
      i_supply_above_263 <= 1;
      wt(0, 0, n); chk_ge("por again", POR, n);
      results();
   end
   initial begin
      repeat (30000) @(posedge i_sys_clk);
      bad_count++;
      $display("[ERR] watchdog exp done got hang");
      results();
   end
endmodule
bind power_sequencer pwr_seq_chk #(.POR_CYC(POR_CYCLES), .LOCK_CYC(PLL_LOCK_CYCLES)) i_pwr_seq_chk (.i_sys_clk,
   .i_nrst, .i_reset_pin, .i_supply_above_263, .i_tic_enabled, .i_tic_irq, .i_spi_irq, .i_spi_irq_en,
   .i_ext0_irq_en, .o_core_rst, .o_core_clk_en, .o_pll_en, .o_periph_en, .o_port_hold, .o_dac_hiz,
   .o_ale_force_low, .o_psen_force_low, .o_pll_locked, .o_wake_irq, .o_wake_src);
